// ===== src/mgmt_pkg.sv
/*
 * Constants for the remote-side management-channel message framer:
 * frame address bytes, 16-bit message field layout, destination codes
 * and buffer sizing.
 * Assumes HDLC flag, stuffing and FCS are handled by a link layer
 * outside this block, which hands over whole frames as byte streams.
 */
// Behaviour
// - both ends use one identical management-channel message format.
// - traffic rides in HDLC frames; flags and FCS handled outside.
// - internal-message payload holds at least two octets.
// - remote unit acknowledges each correct command with a response.
// - the response is an exact copy of the command.
// - remote may send autonomous messages, never as a reply.
// - bidirectional commands are echoed to confirm reception.
// - downstream-only commands are not echoed, answered by another message.
// - upstream messages are replies to downstream ones or autonomous.
// - exactly one echo per bidirectional command; central unit paces the channel.
// - message content sits in the 13 msbs of the two octets.
// - bits 1-2 are the destination field.
// - bit 3 flags data (0) or opcode (1).
// - bit 4 is the byte-order parity flag.
// - bit 5 flags command/echo (1) or autonomous (0).
// - bits 6-13 are the 8-bit information field.
// - bits 14-16 are reserved.
// - commands and echoes use destination 00, autonomous ones 11.
// - data/opcode flag 0 means data byte, 1 means opcode.
// - parity is 1 for opcodes other than next-byte.
// - message flag is 1 for commands and echoes, 0 autonomous.
package mgmt_pkg;

   // ==================================================================
   // frame address bytes
   localparam logic [7:0] HDLC_ADDR_EXT  = 8'hff;
   localparam logic [7:0] HDLC_ADDR_INT  = 8'h11;

   // ==================================================================
   // message layout, bit 1 of the message is bit 15 here
   localparam int         ADDR_HI        = 15;
   localparam int         ADDR_LO        = 14;
   localparam int         OPC_BIT        = 13;
   localparam int         PAR_BIT        = 12;
   localparam int         MSGR_BIT       = 11;
   localparam int         INFO_HI        = 10;
   localparam int         INFO_LO        = 3;
   localparam logic [2:0] RSV_VALUE      = 3'h0;

   // ==================================================================
   // field codes
   localparam logic [1:0] DEST_REMOTE    = 2'h0;
   localparam logic [1:0] DEST_CENTRAL   = 2'h3;
   localparam logic [7:0] OPC_NEXT_BYTE  = 8'h10;

   // ==================================================================
   // buffering
   localparam int         TXQ_WIDTH      = 9;
   localparam int         TXQ_DEPTH      = 4;

   typedef enum logic [1:0] {TX_IDLE, TX_ADDR, TX_HI, TX_LO} tx_state_t;

endpackage : mgmt_pkg

// ===== src/remote_mgmt_entity.sv
/*
 * Remote management entity of the management channel: parses internal
 * messages from received frames, echoes commands, and frames replies
 * and autonomous messages through a small transmit queue.
 * Assumes a link layer that delivers and accepts whole HDLC frames as
 * byte streams with a last marker, and a user that handles commands.
 */
`timescale 1ns/100ps

// ======================================================================
// generic synchronous fifo
module msg_fifo
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
)
(
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   // honest flags; a full queue stalls the framer behind it
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // pointer and level update
   always_comb
   begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push)
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (push & ~pop)
         next_count = count + 1'b1;
      else if (pop & ~push)
         next_count = count - 1'b1;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // storage needs no reset, reads are gated by out_valid
   always_ff @(posedge core_clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

endmodule : msg_fifo

// ======================================================================
// remote end of the channel
module remote_mgmt_entity
(
   input  wire logic       core_clk,
   input  wire logic       reset,
   // frames from the link layer
   input  wire logic       rx_valid,
   input  wire logic [7:0] rx_data,
   input  wire logic       rx_last,
   // frames to the link layer
   output      logic       tx_valid,
   input  wire logic       tx_ready,
   output      logic [7:0] tx_data,
   output      logic       tx_last,
   // commands handed to the user
   output      logic       cmd_valid,
   output      logic       cmd_is_opcode,
   output      logic       cmd_parity,
   output      logic [7:0] cmd_info,
   output      logic       rx_reject,
   // replies and autonomous messages from the user
   input  wire logic       send_valid,
   output      logic       send_ready,
   input  wire logic       send_auto,
   input  wire logic       send_is_opcode,
   input  wire logic       send_parity,
   input  wire logic [7:0] send_info
);
   import mgmt_pkg::*;

   // ===================================================================
   // receive parser
   logic [1:0]  rx_cnt;
   logic [7:0]  rx_addr;
   logic [7:0]  rx_hi;
   logic [7:0]  rx_lo;
   logic [1:0]  next_rx_cnt;
   logic [7:0]  next_rx_addr;
   logic [7:0]  next_rx_hi;
   logic [7:0]  next_rx_lo;
   logic [15:0] rx_msg;
   logic        frame_end;
   logic        int_frame;
   logic        cmd_ok;
   logic        echo_wanted;

   // the closing byte may itself be one of the first three
   always_comb
   begin
      next_rx_cnt  = rx_cnt;
      next_rx_addr = rx_addr;
      next_rx_hi   = rx_hi;
      next_rx_lo   = rx_lo;
      if (rx_valid)
      begin
         if (rx_cnt == 2'd0)
            next_rx_addr = rx_data;
         if (rx_cnt == 2'd1)
            next_rx_hi = rx_data;
         if (rx_cnt == 2'd2)
            next_rx_lo = rx_data;
         if (rx_last)
            next_rx_cnt = 2'd0;
         else if (rx_cnt != 2'd3)
            next_rx_cnt = rx_cnt + 2'd1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rx_cnt  <= 2'd0;
         rx_addr <= 8'h00;
         rx_hi   <= 8'h00;
         rx_lo   <= 8'h00;
      end
      else
      begin
         rx_cnt  <= next_rx_cnt;
         rx_addr <= next_rx_addr;
         rx_hi   <= next_rx_hi;
         rx_lo   <= next_rx_lo;
      end
   end

   assign frame_end = rx_valid & rx_last;
   assign rx_msg    = {next_rx_hi, next_rx_lo};
   // external frames are not ours to parse and are dropped
   assign int_frame = frame_end
                    & (next_rx_addr == HDLC_ADDR_INT);
   // short internal payloads cannot hold a message
   assign cmd_ok    = int_frame & (rx_cnt >= 2'd2)
                    & (rx_msg[ADDR_HI:ADDR_LO] == DEST_REMOTE)
                    & rx_msg[MSGR_BIT];
   // next-byte is downstream only and gets a reply, not an echo
   assign echo_wanted = cmd_ok & ~(rx_msg[OPC_BIT]
                    & (rx_msg[INFO_HI:INFO_LO] == OPC_NEXT_BYTE));

   // ===================================================================
   // command outputs; reserved bits are simply not looked at
   logic       next_cmd_valid;
   logic       next_cmd_is_opcode;
   logic       next_cmd_parity;
   logic [7:0] next_cmd_info;
   logic       next_rx_reject;

   always_comb
   begin
      next_cmd_valid     = cmd_ok;
      next_rx_reject     = int_frame & ~cmd_ok;
      next_cmd_is_opcode = cmd_is_opcode;
      next_cmd_parity    = cmd_parity;
      next_cmd_info      = cmd_info;
      if (cmd_ok)
      begin
         next_cmd_is_opcode = rx_msg[OPC_BIT];
         next_cmd_parity    = rx_msg[PAR_BIT];
         next_cmd_info      = rx_msg[INFO_HI:INFO_LO];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         cmd_valid     <= 1'b0;
         rx_reject     <= 1'b0;
         cmd_is_opcode <= 1'b0;
         cmd_parity    <= 1'b0;
         cmd_info      <= 8'h00;
      end
      else
      begin
         cmd_valid     <= next_cmd_valid;
         rx_reject     <= next_rx_reject;
         cmd_is_opcode <= next_cmd_is_opcode;
         cmd_parity    <= next_cmd_parity;
         cmd_info      <= next_cmd_info;
      end
   end

   // ===================================================================
   // echo holding slot and transmit framer
   tx_state_t   state;
   tx_state_t   next_state;
   logic        echo_pend;
   logic [15:0] echo_msg;
   logic [15:0] tx_msg;
   logic        next_echo_pend;
   logic [15:0] next_echo_msg;
   logic [15:0] next_tx_msg;
   logic        take_echo;
   logic        take_send;
   logic        q_valid;
   logic        q_ready;
   logic [8:0]  q_data;
   logic [8:0]  q_out;
   logic [15:0] send_msg;
   logic [1:0]  send_dest;

   // echoes go first so the central unit sees replies in command order
   assign send_ready = (state == TX_IDLE) & ~echo_pend;
   assign take_echo  = (state == TX_IDLE) & echo_pend;
   assign take_send  = send_ready & send_valid;

   // autonomous ones go to the central unit, replies keep our address
   assign send_dest = send_auto ? DEST_CENTRAL : DEST_REMOTE;
   assign send_msg  = {send_dest,
                       send_is_opcode,
                       send_is_opcode | send_parity,
                       ~send_auto,
                       send_info,
                       RSV_VALUE};

   always_comb
   begin
      // a new command wins over the slot being drained in the same cycle
      next_echo_pend = (echo_pend & ~take_echo) | echo_wanted;
      next_echo_msg  = echo_wanted ? rx_msg : echo_msg;
      next_tx_msg    = tx_msg;
      next_state     = state;
      case (state)
         TX_IDLE:
         begin
            if (take_echo)
            begin
               next_tx_msg = echo_msg;
               next_state  = TX_ADDR;
            end
            else if (take_send)
            begin
               next_tx_msg = send_msg;
               next_state  = TX_ADDR;
            end
         end
         TX_ADDR:
            if (q_ready)
               next_state = TX_HI;
         TX_HI:
            if (q_ready)
               next_state = TX_LO;
         TX_LO:
            if (q_ready)
               next_state = TX_IDLE;
         default:
            next_state = TX_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state     <= TX_IDLE;
         echo_pend <= 1'b0;
         echo_msg  <= 16'h0000;
         tx_msg    <= 16'h0000;
      end
      else
      begin
         state     <= next_state;
         echo_pend <= next_echo_pend;
         echo_msg  <= next_echo_msg;
         tx_msg    <= next_tx_msg;
      end
   end

   // one internal frame: address byte then the two message octets
   always_comb
   begin
      q_valid = 1'b1;
      case (state)
         TX_ADDR: q_data = {1'b0, HDLC_ADDR_INT};
         TX_HI:   q_data = {1'b0, tx_msg[15:8]};
         TX_LO:   q_data = {1'b1, tx_msg[7:0]};
         default:
         begin
            q_valid = 1'b0;
            q_data  = 9'h000;
         end
      endcase
   end

   msg_fifo #(
      .WIDTH (TXQ_WIDTH),
      .DEPTH (TXQ_DEPTH)
   ) tx_queue (
      .core_clk  (core_clk),
      .reset     (reset),
      .in_valid  (q_valid),
      .in_ready  (q_ready),
      .in_data   (q_data),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_data  (q_out)
   );

   assign tx_data = q_out[7:0];
   assign tx_last = q_out[8];

endmodule : remote_mgmt_entity

// ===== verif/remote_mgmt_props.sv
/* port checker for the remote management entity.
   assumes one clock and the synchronous active-high reset of the top. */
`timescale 1ns/100ps
// ==================================================================
// properties on the top ports
module remote_mgmt_props
   import mgmt_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       reset,
   input wire logic       rx_valid,
   input wire logic       rx_last,
   input wire logic       tx_valid,
   input wire logic       tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic       tx_last,
   input wire logic       cmd_valid,
   input wire logic       cmd_is_opcode,
   input wire logic       cmd_parity,
   input wire logic [7:0] cmd_info,
   input wire logic       rx_reject,
   input wire logic       send_valid,
   input wire logic       send_ready
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (reset);

   // answers only follow the end of a received frame
   chk_cmd_cause:
      assert property (cmd_valid |-> $past(rx_valid && rx_last))
      else $error("command pulse without a frame end");
   chk_rej_cause:
      assert property (rx_reject |-> $past(rx_valid && rx_last) && !cmd_valid)
      else $error("reject pulse without a frame end");
   chk_cmd_pulse:
      assert property (cmd_valid |=> !cmd_valid && !rx_reject)
      else $error("command pulse longer than one cycle");
   // an echo-wanted command reaches the link within two cycles
   chk_echo_time:
      assert property (cmd_valid && !(cmd_is_opcode &&
                       cmd_info == OPC_NEXT_BYTE) |-> ##[1:2] tx_valid)
      else $error("echo not offered in time");
   chk_tx_hold:
      assert property (tx_valid && !tx_ready |=>
                       tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("tx byte changed while stalled");
   chk_fld_hold:
      assert property (!cmd_valid |->
                       $stable({cmd_is_opcode, cmd_parity, cmd_info}))
      else $error("command fields changed without a command");
   chk_send_busy:
      assert property (send_valid && send_ready |=> !send_ready [*3])
      else $error("send taken again before the frame was queued");
   chk_send_addr:
      assert property (send_valid && send_ready && !tx_valid |->
                       ##2 tx_valid && tx_data == HDLC_ADDR_INT)
      else $error("send frame does not open with internal address");
endmodule : remote_mgmt_props

bind remote_mgmt_entity remote_mgmt_props u_props
(
   .core_clk(core_clk), .reset(reset), .rx_valid(rx_valid),
   .rx_last(rx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .tx_data(tx_data), .tx_last(tx_last), .cmd_valid(cmd_valid),
   .cmd_is_opcode(cmd_is_opcode), .cmd_parity(cmd_parity),
   .cmd_info(cmd_info), .rx_reject(rx_reject),
   .send_valid(send_valid), .send_ready(send_ready)
);

// ===== verif/central_model.sv
/* behavioural central unit on the far side of the link.
   assumes byte-wide frame streams and a bench that calls put_frame. */
`timescale 1ns/100ps
// ==================================================================
// central end: sends command frames, collects upstream bytes
module central_model
(
   input  wire logic       core_clk,
   input  wire logic       stall,
   output      logic       rx_valid,
   output      logic [7:0] rx_data,
   output      logic       rx_last,
   input  wire logic       tx_valid,
   output      logic       tx_ready,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last
);
   logic [8:0] got [$];

   initial
   begin
      {rx_valid, rx_last} = 2'h0;
      rx_data = 8'h00;
   end
   // back-pressure only when the bench asks, to fill the queue
   always @(negedge core_clk)
      tx_ready <= !stall;
   // upstream bytes kept as {last, data}
   always @(posedge core_clk)
      if (tx_valid && tx_ready)
         got.push_back({tx_last, tx_data});
   // address byte, then n payload bytes, msb first
   task automatic put_frame(input logic [7:0] adr, input logic [15:0] msg,
                            input int n);
      logic [7:0] b [3];
      b = '{adr, msg[15:8], msg[7:0]};
      for (int i = 0; i <= n; i++)
      begin
         @(negedge core_clk);
         {rx_valid, rx_last, rx_data} = {1'b1, i == n, b[i]};
      end
      @(negedge core_clk);
      {rx_valid, rx_last, rx_data} = {2'b00, ~rx_data}; // stale data hidden
   endtask : put_frame
endmodule : central_model

// ===== verif/tb.sv
/* self-checking bench for the remote management entity.
   assumes central_model as far end and the bound port checker. */
`timescale 1ns/100ps
// ==================================================================
// bench top
module tb;
   import mgmt_pkg::*;
   logic       core_clk, reset, stall, rx_valid, rx_last, tx_valid, tx_ready;
   logic       tx_last, cmd_valid, cmd_is_opcode, cmd_parity, rx_reject;
   logic       send_valid, send_ready, send_auto, send_is_opcode, send_parity;
   logic [7:0] rx_data, tx_data, cmd_info, send_info;
   int         fails = 0, comparisons = 0, n_cmd = 0, n_rej = 0;

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   remote_mgmt_entity u_dut (.core_clk(core_clk), .reset(reset),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .tx_last(tx_last), .cmd_valid(cmd_valid), .cmd_parity(cmd_parity),
      .cmd_is_opcode(cmd_is_opcode), .cmd_info(cmd_info),
      .rx_reject(rx_reject), .send_valid(send_valid),
      .send_ready(send_ready), .send_auto(send_auto),
      .send_is_opcode(send_is_opcode), .send_parity(send_parity),
      .send_info(send_info));
   central_model u_far (.core_clk(core_clk), .stall(stall),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .tx_last(tx_last));
   // tally one-cycle answers of the receive side
   always @(posedge core_clk)
   begin
      if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
      if (rx_reject === 1'b1) n_rej <= n_rej + 1;
   end

   // ==================================================================
   // helpers
   function automatic logic [15:0] mk(input logic [1:0] d,
      input logic [2:0] f, input logic [7:0] info, input logic [2:0] r);
      return {d, f, info, r};
   endfunction : mk
   task automatic chk(input string what, input logic [15:0] e,
                      input logic [15:0] s);
      comparisons++;
      if (s !== e)
      begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, e, s);
      end
   endtask : chk
   // pops one upstream frame: address, high, low with last
   task automatic chk_frame(input logic [15:0] m);
      logic [8:0] b [3];
      chk("frame present", 16'h0001, 16'(u_far.got.size() >= 3));
      if (u_far.got.size() >= 3)
      begin
         foreach (b[i])
            b[i] = u_far.got.pop_front();
         chk("tx addr", 16'h0011, {7'h00, b[0]});
         chk("tx hi", {8'h00, m[15:8]}, {7'h00, b[1]});
         chk("tx lo", {8'h01, m[7:0]}, {7'h00, b[2]});
      end
   endtask : chk_frame
   task automatic cmd_round(input logic [15:0] m, input logic echo);
      int c0;
      c0 = n_cmd;
      u_far.put_frame(HDLC_ADDR_INT, m, 2);
      repeat (12) @(negedge core_clk);
      chk("cmd count", 16'(c0 + 1), 16'(n_cmd));
      chk("cmd fields", {6'h00, m[13:12], m[10:3]},
          {6'h00, cmd_is_opcode, cmd_parity, cmd_info});
      if (echo)
         chk_frame(m);
      else
         chk("no echo", 16'h0000, 16'(u_far.got.size()));
   endtask : cmd_round
   task automatic do_send(input logic a, input logic [1:0] op_par,
                          input logic [7:0] info);
      @(negedge core_clk);
      {send_auto, send_is_opcode, send_parity, send_info} = {a, op_par, info};
      send_valid = 1'b1;
      while (send_ready !== 1'b1) @(negedge core_clk);
      @(negedge core_clk);
      send_valid = 1'b0;
   endtask : do_send

   // ==================================================================
   // scenarios
   task automatic t_echo_kinds;
      cmd_round(mk(2'h0, 3'h7, 8'h02, 3'h5), 1'b1);
      cmd_round(mk(2'h0, 3'h1, 8'ha5, 3'h0), 1'b1);
      cmd_round(mk(2'h0, 3'h7, OPC_NEXT_BYTE, 3'h0), 1'b0);
   endtask : t_echo_kinds
   task automatic t_rejects;
      logic [15:0] bad [4];
      int c0, r0;
      bad = '{mk(2'h3, 3'h7, 8'h01, 3'h0), mk(2'h1, 3'h7, 8'h01, 3'h0),
              mk(2'h0, 3'h6, 8'h01, 3'h0), mk(2'h0, 3'h7, 8'h01, 3'h0)};
      foreach (bad[i])
      begin
         {c0, r0} = {n_cmd, n_rej};
         u_far.put_frame(HDLC_ADDR_INT, bad[i], (i == 3) ? 1 : 2);
         repeat (4) @(negedge core_clk);
         chk("reject count", 16'(r0 + 1),
             16'(n_rej));
         chk("no cmd", 16'(c0), 16'(n_cmd));
      end
      // c0 and r0 still hold the counts from before the last reject
      u_far.put_frame(HDLC_ADDR_EXT, mk(2'h0, 3'h7, 8'h02, 3'h0), 2);
      repeat (12) @(negedge core_clk);
      chk("ext dropped", 16'(c0 + r0 + 1), 16'(n_cmd + n_rej));
      chk("no reply", 16'h0000, 16'(u_far.got.size()));
   endtask : t_rejects
   task automatic t_send_fill;
      stall = 1'b1;
      do_send(1'b0, 2'h2, 8'h04);
      do_send(1'b1, 2'h0, 8'h5a);
      repeat (10) @(negedge core_clk);
      chk("full refuses", 16'h0001,
          {15'h0000, tx_valid & ~send_ready});
      stall = 1'b0;
      do_send(1'b0, 2'h1, 8'h3c);
      repeat (20) @(negedge core_clk);
      chk_frame(mk(2'h0, 3'h7, 8'h04, 3'h0));
      chk_frame(mk(2'h3, 3'h0, 8'h5a, 3'h0));
      chk_frame(mk(2'h0, 3'h3, 8'h3c, 3'h0));
   endtask : t_send_fill
   task automatic t_reset_mid;
      stall = 1'b1;
      u_far.put_frame(HDLC_ADDR_INT, mk(2'h0, 3'h7, 8'h14, 3'h0), 2);
      repeat (8) @(negedge core_clk);
      reset = 1'b1;
      repeat (2) @(negedge core_clk);
      reset = 1'b0;
      chk("after reset", 16'h0100,
          {6'h00, tx_valid, send_ready, cmd_info});
      stall = 1'b0;
   endtask : t_reset_mid

   // ==================================================================
   // verdict and run control
   task automatic wrap_up;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   initial
   begin
      {reset, stall, send_valid, send_auto, send_is_opcode, send_parity} = 6'h20;
      send_info = 8'h00;
      repeat (5) @(negedge core_clk);
      reset = 1'b0;
      t_echo_kinds();
      t_rejects();
      t_send_fill();
      t_reset_mid();
      wrap_up();
   end
   // under two hundred cycles expected; cut a hang well beyond that
   initial
   begin
      #100000;
      fails++;
      wrap_up();
   end
endmodule : tb
